// >>> rtl/peepw_pkg.sv
// constants for the host-side controller of a byte-wide page-write eeprom
// assumes a 50 MHz core clock; all times below are turned into cycle counts here
package peepw_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// device geometry
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int PAGE_BYTES = 64;
	localparam int BYTE_W = 6;
	localparam logic [12:0] ID_AREA_BASE = 13'h1FC0;
	// strobe and access timing in ns, least times rounded up
	localparam int WP_NS = 200;
	localparam int WPH_NS = 100;
	localparam int ACC_NS = 200;
	localparam int DF_NS = 55;
	localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DF_CYC = (DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CYC = 3;
	localparam int RD_CYC = ACC_CYC + SYNC_CYC;
	// byte load window, a longest time, rounded down; host closes early by a margin
	localparam int BLC_US = 100;
	localparam int BLC_CYC = (BLC_US * 1000) / CLK_PERIOD_NS;
	localparam int BLC_MARGIN_CYC = 500;
	// write cycle and power-on lockout, in ms
	localparam int WC_MS = 10;
	localparam int WC_CYC = (WC_MS * 1000000) / CLK_PERIOD_NS;
	localparam int LOCKOUT_MS = 10;
	localparam int LOCKOUT_CYC = (LOCKOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 5;
	localparam int LONG_W = 20;
endpackage

// >>> rtl/peepw_host.sv
// host controller that drives a byte-wide page-write eeprom through its pins
// assumes the testbench resolves the data_lines wire from data_lines_oe_out and the device model
`timescale 1ns/10ps
`default_nettype none

// Function
// - write starts on strobe low, gate high
// - one page load holds 1 to 64 bytes
// - next page byte within 100 us
// - page lines stay fixed during one load
// - three unlock writes precede every write
// - unlock writes use page-load timing
module peepw_host #(
	parameter logic [12:0] UNLOCK_ADDR0 = 13'h0AAA,
	parameter logic [12:0] UNLOCK_ADDR1 = 13'h0555,
	parameter logic [12:0] UNLOCK_ADDR2 = 13'h0AAA,
	parameter logic [7:0] UNLOCK_DATA0 = 8'hAA,
	parameter logic [7:0] UNLOCK_DATA1 = 8'h55,
	parameter logic [7:0] UNLOCK_DATA2 = 8'hA0,
	parameter int WC_LIMIT_CYC = peepw_pkg::WC_CYC,
	parameter int LOCKOUT_LIMIT_CYC = peepw_pkg::LOCKOUT_CYC,
	parameter int BLC_LIMIT_CYC = peepw_pkg::BLC_CYC
) (
	// clock, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	// user command port
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic cmd_last_in,
	input wire logic cmd_id_area_in,
	input wire logic [peepw_pkg::ADDR_W-1:0] cmd_addr_in,
	input wire logic [peepw_pkg::DATA_W-1:0] cmd_data_in,
	output logic cmd_ready_out,
	// user answer port
	output logic rsp_valid_out,
	output logic [peepw_pkg::DATA_W-1:0] rsp_data_out,
	output logic wr_done_out,
	output logic wr_err_out,
	// device pins
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic id_area_select_line_out,
	output logic [peepw_pkg::ADDR_W-1:0] address_lines_out,
	output logic [peepw_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe_out,
	input wire logic [peepw_pkg::DATA_W-1:0] data_lines_in
);
	import peepw_pkg::*;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_STROBE = 8'h02,
		S_RECOVER = 8'h04,
		S_LOAD = 8'h08,
		S_POLL = 8'h10,
		S_POLL_GAP = 8'h20,
		S_READ = 8'h40,
		S_READ_GAP = 8'h80
	} peepw_state_e;

	peepw_state_e state_q;
	logic [TMR_W-1:0] tmr_q;
	logic [12:0] blc_q;
	logic [LONG_W-1:0] wc_q;
	logic [LONG_W-1:0] lock_q;
	logic [1:0] step_q;
	logic [6:0] cnt_q;
	logic [6:0] page_q;
	logic id_q;
	logic last_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [DATA_W-1:0] wdata_q;
	logic prev_ok_q;
	logic prev6_q;
	logic [DATA_W-1:0] sync1_q, sync2_q, sync3_q;

	// the id area sits at the top 64 bytes; only the byte lines come from the user
	function automatic logic [ADDR_W-1:0] map_addr(input logic id, input logic [ADDR_W-1:0] a);
		map_addr = id ? (ID_AREA_BASE | {7'h00, a[BYTE_W-1:0]}) : a;
	endfunction

	function automatic logic [ADDR_W-1:0] unlock_addr(input logic [1:0] idx);
		unlock_addr = (idx == 2'h0) ? UNLOCK_ADDR0 : (idx == 2'h1) ? UNLOCK_ADDR1 : UNLOCK_ADDR2;
	endfunction

	function automatic logic [DATA_W-1:0] unlock_data(input logic [1:0] idx);
		unlock_data = (idx == 2'h0) ? UNLOCK_DATA0 : (idx == 2'h1) ? UNLOCK_DATA1 : UNLOCK_DATA2;
	endfunction

	wire lockout_done = (lock_q >= LONG_W'(LOCKOUT_LIMIT_CYC));
	wire tmr_zero = (tmr_q == '0);
	wire in_stable = (sync2_q == sync3_q);
	wire take = cmd_valid_in & cmd_ready_out;
	wire [1:0] next_step = step_q + 2'h1;
	// the page lines of every later byte are forced to those of the first
	wire [ADDR_W-1:0] page_addr = map_addr(id_q, {page_q, cmd_addr_in[BYTE_W-1:0]});
	wire blc_expired = (blc_q >= 13'(BLC_LIMIT_CYC - BLC_MARGIN_CYC));
	wire poll_match = (sync3_q[7] == wdata_q[7]) & prev_ok_q & (sync3_q[6] == prev6_q);
	wire wc_over = (wc_q >= LONG_W'(WC_LIMIT_CYC + WC_LIMIT_CYC / 2));

	// data pins are asynchronous to the core clock
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
			sync3_q <= 8'h00;
		end else if (clk_en_in) begin
			sync1_q <= data_lines_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lock_q <= '0;
		end else if (clk_en_in && !lockout_done) begin
			lock_q <= lock_q + LONG_W'(1);
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= S_IDLE;
			tmr_q <= '0;
			blc_q <= '0;
			wc_q <= '0;
			step_q <= 2'h0;
			cnt_q <= 7'h00;
			page_q <= 7'h00;
			id_q <= 1'b0;
			last_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 8'h00;
			prev_ok_q <= 1'b0;
			prev6_q <= 1'b0;
			cmd_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 8'h00;
			wr_done_out <= 1'b0;
			wr_err_out <= 1'b0;
			ce_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			we_n_out <= 1'b1;
			id_area_select_line_out <= 1'b0;
			address_lines_out <= '0;
			data_lines_out <= 8'h00;
			data_lines_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			rsp_valid_out <= 1'b0;
			wr_done_out <= 1'b0;
			wr_err_out <= 1'b0;
			if (!tmr_zero) begin
				tmr_q <= tmr_q - TMR_W'(1);
			end
			case (state_q)
				S_IDLE: begin
					cmd_ready_out <= lockout_done;
					if (take) begin
						cmd_ready_out <= 1'b0;
						id_q <= cmd_id_area_in;
						id_area_select_line_out <= cmd_id_area_in;
						if (cmd_write_in) begin
							// every write opens with the unlock series; protection is back after each cycle
							page_q <= cmd_addr_in[12:6];
							waddr_q <= map_addr(cmd_id_area_in, cmd_addr_in);
							wdata_q <= cmd_data_in;
							last_q <= cmd_last_in;
							step_q <= 2'h0;
							cnt_q <= 7'h00;
							address_lines_out <= unlock_addr(2'h0);
							data_lines_out <= unlock_data(2'h0);
							data_lines_oe_out <= 1'b1;
							oe_n_out <= 1'b1;
							ce_n_out <= 1'b0;
							we_n_out <= 1'b0;
							tmr_q <= TMR_W'(WP_CYC - 1);
							state_q <= S_STROBE;
						end else begin
							address_lines_out <= map_addr(cmd_id_area_in, cmd_addr_in);
							ce_n_out <= 1'b0;
							oe_n_out <= 1'b0;
							tmr_q <= TMR_W'(RD_CYC);
							state_q <= S_READ;
						end
					end
				end
				S_STROBE: begin
					// a full-width pulse keeps the device glitch filter from swallowing it
					if (tmr_zero) begin
						we_n_out <= 1'b1;
						ce_n_out <= 1'b1;
						tmr_q <= TMR_W'(WPH_CYC - 1);
						state_q <= S_RECOVER;
					end
				end
				S_RECOVER: begin
					data_lines_oe_out <= 1'b0;
					if (tmr_zero) begin
						if (step_q != 2'h3) begin
							// unlock writes keep the same strobe and load timing as page bytes
							step_q <= next_step;
							address_lines_out <= (next_step == 2'h3) ? waddr_q : unlock_addr(next_step);
							data_lines_out <= (next_step == 2'h3) ? wdata_q : unlock_data(next_step);
							data_lines_oe_out <= 1'b1;
							ce_n_out <= 1'b0;
							we_n_out <= 1'b0;
							tmr_q <= TMR_W'(WP_CYC - 1);
							state_q <= S_STROBE;
						end else begin
							cnt_q <= cnt_q + 7'h01;
							blc_q <= 13'h0000;
							if (last_q || cnt_q == 7'(PAGE_BYTES - 1)) begin
								wc_q <= '0;
								prev_ok_q <= 1'b0;
								tmr_q <= TMR_W'(DF_CYC);
								state_q <= S_POLL_GAP;
							end else begin
								cmd_ready_out <= 1'b1;
								state_q <= S_LOAD;
							end
						end
					end
				end
				S_LOAD: begin
					blc_q <= blc_q + 13'h0001;
					if (take && cmd_write_in && cmd_id_area_in == id_q) begin
						cmd_ready_out <= 1'b0;
						waddr_q <= page_addr;
						wdata_q <= cmd_data_in;
						last_q <= cmd_last_in;
						address_lines_out <= page_addr;
						data_lines_out <= cmd_data_in;
						data_lines_oe_out <= 1'b1;
						ce_n_out <= 1'b0;
						we_n_out <= 1'b0;
						tmr_q <= TMR_W'(WP_CYC - 1);
						state_q <= S_STROBE;
					end else if (blc_expired || cmd_valid_in) begin
						// closing early leaves the device to start programming on its own
						cmd_ready_out <= 1'b0;
						wc_q <= '0;
						prev_ok_q <= 1'b0;
						tmr_q <= TMR_W'(DF_CYC);
						state_q <= S_POLL_GAP;
					end
				end
				S_POLL_GAP: begin
					wc_q <= wc_q + LONG_W'(1);
					if (wc_over) begin
						wr_err_out <= 1'b1;
						wr_done_out <= 1'b1;
						state_q <= S_READ_GAP;
					end else if (tmr_zero) begin
						address_lines_out <= waddr_q;
						ce_n_out <= 1'b0;
						oe_n_out <= 1'b0;
						tmr_q <= TMR_W'(RD_CYC);
						state_q <= S_POLL;
					end
				end
				S_POLL: begin
					wc_q <= wc_q + LONG_W'(1);
					if (tmr_zero && in_stable) begin
						ce_n_out <= 1'b1;
						oe_n_out <= 1'b1;
						prev6_q <= sync3_q[6];
						prev_ok_q <= 1'b1;
						tmr_q <= TMR_W'(DF_CYC);
						if (poll_match) begin
							wr_done_out <= 1'b1;
							state_q <= S_READ_GAP;
						end else begin
							state_q <= S_POLL_GAP;
						end
					end
				end
				S_READ: begin
					if (tmr_zero && in_stable) begin
						ce_n_out <= 1'b1;
						oe_n_out <= 1'b1;
						rsp_data_out <= sync3_q;
						rsp_valid_out <= 1'b1;
						tmr_q <= TMR_W'(DF_CYC);
						state_q <= S_READ_GAP;
					end
				end
				S_READ_GAP: begin
					ce_n_out <= 1'b1;
					oe_n_out <= 1'b1;
					// the device may still drive the bus for its float time
					if (tmr_zero) begin
						id_area_select_line_out <= 1'b0;
						cmd_ready_out <= lockout_done;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// >>> test/peepw_host_properties.sv
// assertions on the pins and answer pulses of the eeprom host
// bound onto peepw_host; one clock domain
`timescale 1ns/10ps
`default_nettype none
module peepw_host_properties #(parameter int LOCKOUT_LIMIT_CYC = 20) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// answers
	input wire logic cmd_ready_out,
	input wire logic wr_done_out,
	input wire logic wr_err_out,
	// device pins
	input wire logic ce_n_out,
	input wire logic oe_n_out,
	input wire logic we_n_out,
	input wire logic [12:0] address_lines_out,
	input wire logic data_lines_oe_out
);
	int up_q;
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			up_q <= 0;
		end else if (up_q < LOCKOUT_LIMIT_CYC) begin
			up_q <= up_q + 1;
		end
	end
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence s_strobe_low;
		(!we_n_out)[*8] ##1 !we_n_out ##1 !we_n_out ##1 we_n_out;
	endsequence
	a_strobe_width: assert property ($fell(we_n_out) |-> s_strobe_low) else $error("strobe width");
	a_strobe_gap: assert property ($rose(we_n_out) |-> we_n_out[*5]) else $error("strobe gap");
	a_write_gate: assert property (!we_n_out |-> !ce_n_out && oe_n_out && data_lines_oe_out) else $error("write gate");
	a_read_gate: assert property (!oe_n_out |-> !ce_n_out && we_n_out && !data_lines_oe_out) else $error("read gate");
	a_addr_hold: assert property (!we_n_out && $past(!we_n_out) |-> $stable(address_lines_out)) else $error("addr");
	a_read_len: assert property ($fell(oe_n_out) |-> (!oe_n_out)[*8] ##1 (!oe_n_out)[*5]) else $error("read short");
	a_lock_wait: assert property (cmd_ready_out |-> up_q == LOCKOUT_LIMIT_CYC) else $error("lockout");
	a_err_done: assert property (wr_err_out |-> wr_done_out) else $error("err alone");
endmodule
bind peepw_host peepw_host_properties #(.LOCKOUT_LIMIT_CYC(LOCKOUT_LIMIT_CYC)) i_chk (.core_clk_in, .rst_b_in,
	.cmd_ready_out, .wr_done_out, .wr_err_out, .ce_n_out, .oe_n_out, .we_n_out, .address_lines_out, .data_lines_oe_out);
`default_nettype wire

// >>> test/peepw_dev_model.sv
// behavioural page-write eeprom on the far side of the host
// pins sampled on the bench clock; its timers are shorter than the maxima
`timescale 1ns/10ps
`default_nettype none
module peepw_dev_model #(parameter int WC = 150, parameter int WIN = 60, parameter int LOCK = 20) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// strobes, address, data
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic id_sel_in,
	input wire logic [12:0] addr_in,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe_out
);
	logic [7:0] mem [8192];
	logic [7:0] idm [64];
	logic [7:0] pd [64];
	logic [63:0] pv;
	logic [6:0] pg;
	logic [12:0] la;
	logic [7:0] dl, lv;
	logic wl_q, rd_q, tog, b7, idp;
	int unl, lock, win, busy;
	wire logic wl = !ce_n_in && !we_n_in && oe_n_in;
	wire logic rd = !ce_n_in && !oe_n_in && we_n_in;
	// unlock codes {addr, data}, arbitrary values kept equal to the host defaults
	wire logic [20:0] code = unl == 0 ? 21'h0AAAAA : unl == 1 ? 21'h055555 : 21'h0AAAA0;
	wire logic in_id = id_sel_in && addr_in[12:6] == 7'h7F;
	wire logic [7:0] rv = win > 0 || busy > 0 ? {!b7, tog, 6'h2A} : in_id ? idm[addr_in[5:0]] : mem[addr_in];
	assign dq_oe_out = rd;
	// released lines show the inverse of the last value, not a held copy
	assign dq_out = rd ? rv : ~lv;
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		foreach (idm[i]) idm[i] = 8'hFF;
	end
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lock <= LOCK;
			unl <= 0;
			win <= 0;
			busy <= 0;
			pv <= '0;
			tog <= 1'b0;
			wl_q <= 1'b0;
			rd_q <= 1'b0;
			lv <= 8'h00;
		end else begin
			// pins are sampled each clock, so a pulse that falls between two edges never opens a write
			wl_q <= wl;
			rd_q <= rd;
			if (rd) lv <= rv;
			if (lock > 0) lock <= lock - 1;
			if (busy > 0) busy <= busy - 1;
			if (rd && !rd_q && (win > 0 || busy > 0)) tog <= !tog;
			if (wl && !wl_q) la <= addr_in;
			if (wl) dl <= dq_in;
			if (win > 0) win <= win - 1;
			if (win == 1) begin
				for (int i = 0; i < 64; i++) begin
					if (pv[i] && idp) idm[i] <= pd[i];
					if (pv[i] && !idp) mem[{pg, i[5:0]}] <= pd[i];
				end
				pv <= '0;
				unl <= 0;
				busy <= WC;
			end
			if (!wl && wl_q && lock == 0 && busy == 0) begin
				b7 <= dl[7];
				if (unl < 3 && {la, dl} == code) begin
					unl <= unl + 1;
				end else if (unl < 3) begin
					unl <= 0;
					busy <= WC;
				end else begin
					pd[la[5:0]] <= dl;
					pv[la[5:0]] <= 1'b1;
					pg <= la[12:6];
					idp <= id_sel_in;
					win <= WIN;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the eeprom host controller
// commands driven on falling edges; device model on the far side
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk, rst_b, en, v, w, lst, idr;
	logic [12:0] a;
	logic [7:0] d;
	logic [8:0] qd;
	logic [31:0] seed = 32'hD3B94809;
	logic [8:0] expq [$];
	int n_fail = 0;
	int num_checks = 0;
	wire logic rdy, rv, done, err, ce_n, oe_n, we_n, ids, doe, moe;
	wire logic [7:0] rdat, hd, md, dw;
	wire logic [12:0] al;
	assign dw = doe ? hd : md;
	peepw_host #(.WC_LIMIT_CYC(200), .LOCKOUT_LIMIT_CYC(20), .BLC_LIMIT_CYC(1000)) i_peepw_host (.core_clk_in(clk),
		.rst_b_in(rst_b), .clk_en_in(en), .cmd_valid_in(v), .cmd_write_in(w), .cmd_last_in(lst), .cmd_id_area_in(idr),
		.cmd_addr_in(a), .cmd_data_in(d), .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rdat),
		.wr_done_out(done), .wr_err_out(err), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n),
		.id_area_select_line_out(ids), .address_lines_out(al), .data_lines_out(hd), .data_lines_oe_out(doe),
		.data_lines_in(dw));
	peepw_dev_model i_peepw_dev_model (.core_clk_in(clk), .rst_b_in(rst_b), .ce_n_in(ce_n), .oe_n_in(oe_n),
		.we_n_in(we_n), .id_sel_in(ids), .addr_in(al), .dq_in(dw), .dq_out(md), .dq_oe_out(moe));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic conclude;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// m = {write, last, id}; on a read dt is the expected byte
	task automatic op(input logic [2:0] m, input logic [12:0] ad, input logic [7:0] dt);
		int n;
		n = 0;
		@(negedge clk);
		{v, w, lst, idr} = {1'b1, m};
		a = ad;
		d = dt;
		while (rdy !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n == 5000) begin
			n_fail++;
			$display("Error %0t: command never taken", $time);
		end
		if (m[2:1] == 2'b11) expq.push_back(9'h100);
		if (!m[2]) expq.push_back({1'b0, dt});
		@(negedge clk);
		v = 1'b0;
	endtask
	always @(negedge clk) begin
		if (doe === 1'b1 && moe === 1'b1) begin
			n_fail++;
			$display("Error %0t: both sides drive data", $time);
		end
		if (rv === 1'b1 || done === 1'b1) begin
			qd = expq.size() > 0 ? expq.pop_front() : 9'h1FF;
			num_checks++;
			if (done === 1'b1 ? (qd !== 9'h100 || err !== 1'b0) : qd !== {1'b0, rdat}) begin
				n_fail++;
				$display("Error %0t: got %h done %b want %h", $time, rdat, done, qd);
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#800000;
		n_fail++;
		conclude;
	end
	initial begin
		logic [7:0] x [3];
		logic [6:0] p;
		{rst_b, v, w, lst, idr, a, d} = '0;
		en = 1'b1;
		foreach (x[i]) x[i] = rnd();
		p = {1'b1, x[0][5:0]};
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		op(3'b100, {p, 6'h3F}, x[0]);
		op(3'b100, {p, 6'h00}, x[1]);
		op(3'b100, {p, 6'h3F}, x[2]);
		op(3'b110, {p, 6'h05}, x[1]);
		op(3'b000, {p, 6'h3F}, x[2]);
		op(3'b000, {p, 6'h00}, x[1]);
		op(3'b000, {p, 6'h05}, x[1]);
		op(3'b000, {p, 6'h01}, 8'hFF);
		op(3'b000, 13'h0AAA, 8'hFF);
		$display("test page done");
		op(3'b111, 13'h0003, x[2]);
		op(3'b001, 13'h0003, x[2]);
		op(3'b000, 13'h1FC3, 8'hFF);
		op(3'b110, 13'h0555, x[0]);
		op(3'b000, 13'h0555, x[0]);
		$display("test id and unlock done");
		while (rdy !== 1'b1) @(negedge clk);
		// a frozen host must neither launch a pending read nor drop ready
		en = 1'b0;
		{v, w, idr, a} = {1'b1, 1'b0, 1'b0, 13'h0040};
		repeat (2 + rnd() % 6) begin
			@(negedge clk);
			num_checks++;
			if (ce_n !== 1'b1 || rdy !== 1'b1) begin
				n_fail++;
				$display("Error %0t: host moved while disabled", $time);
			end
		end
		v = 1'b0;
		en = 1'b1;
		// a page left open past its window is closed by the host and still programmed
		op(3'b100, 13'h0100, x[1]);
		expq.push_back(9'h100);
		repeat (600) @(negedge clk);
		op(3'b000, 13'h0100, x[1]);
		$display("test enable and window done");
		for (int i = 0; i < 64; i++) op(3'b100, {7'h01, i[5:0]}, i[7:0] ^ x[0]);
		expq.push_back(9'h100);
		op(3'b000, 13'h0040, x[0]);
		op(3'b000, 13'h007F, 8'h3F ^ x[0]);
		for (int n = 0; n < 5000 && expq.size() > 0; n++) @(negedge clk);
		if (expq.size() > 0) begin
			n_fail++;
			$display("Error %0t: answers still outstanding", $time);
		end
		$display("test full page done");
		conclude;
	end
endmodule
`default_nettype wire
